// [common/pwm_led_pkg.sv]
package pwm_led_pkg;

	////////////////////////////////////////////////////////////////////////
	// sizes
	localparam int CHANNELS = 16;
	localparam int CNT_W = 12;
	localparam int CHAN_BYTES = 64;

	////////////////////////////////////////////////////////////////////////
	// clocking
	localparam int CLOCK_HZ = 50_000_000;
	localparam int INT_OSC_HZ = 25_000_000;
	localparam int OSC_DIV = CLOCK_HZ / INT_OSC_HZ;
	localparam logic [1:0] OSC_DIV_LAST = 2'(OSC_DIV - 1);
	localparam int EXT_CLK_MAX_HZ = 50_000_000;
	localparam int BUS_MAX_HZ = 1_000_000;
	localparam int BUS_CYCLES_PER_BIT = CLOCK_HZ / BUS_MAX_HZ;

	////////////////////////////////////////////////////////////////////////
	// register offsets on the serial bus
	localparam logic [7:0] REG_MODE1 = 8'h00;
	localparam logic [7:0] REG_MODE2 = 8'h01;
	localparam logic [7:0] REG_SUB1 = 8'h02;
	localparam logic [7:0] REG_SUB2 = 8'h03;
	localparam logic [7:0] REG_SUB3 = 8'h04;
	localparam logic [7:0] REG_ALL_ADDR = 8'h05;
	localparam logic [7:0] REG_CHAN_BASE = 8'h06;
	localparam logic [7:0] REG_CHAN_LAST = 8'h45;
	localparam logic [7:0] REG_PRESCALE = 8'hfe;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int MODE1_ALL_EN = 0;
	localparam int MODE1_SUB_EN_LO = 1;
	localparam int MODE1_EXT_CLK = 6;
	localparam int MODE2_FORCE_LVL = 0;
	localparam int MODE2_FORCE_HIZ = 1;
	localparam int MODE2_TOTEM = 2;
	localparam int MODE2_ON_ACK = 3;
	localparam int CHAN_FULL_BIT = 4;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0] MODE1_RESET = 8'h01;
	localparam logic [7:0] MODE2_RESET = 8'h04;
	localparam logic [7:0] SUB_RESET = 8'h00;
	localparam logic [7:0] ALL_ADDR_RESET = 8'he0;
	localparam logic [7:0] PRESCALE_RESET = 8'h1e;
	localparam logic [7:0] CHAN_OFF_H_RESET = 8'h10;
	localparam logic [7:0] CHAN_BYTE_RESET = 8'h00;
	localparam logic [15:0] OUT_EN_RESET = 16'hffff;

	////////////////////////////////////////////////////////////////////////
	// bus addressing
	localparam logic OWN_ADDR_TOP = 1'b1;
	localparam logic [6:0] GENERAL_CALL = 7'h00;
	localparam logic [7:0] SOFT_RESET_BYTE = 8'h06;

	typedef enum logic [6:0] {
		S_IDLE = 7'b0000001,
		S_ADDR = 7'b0000010,
		S_ACK_ADDR = 7'b0000100,
		S_WRITE = 7'b0001000,
		S_ACK_WR = 7'b0010000,
		S_READ = 7'b0100000,
		S_ACK_RD = 7'b1000000
	} slave_state_type;

endpackage

// [rtl/serial_slave.sv]
`timescale 1ns/1ps
module serial_slave (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic [6:0] ownAddr,
	input wire logic [6:0] allAddr,
	input wire logic allEn,
	input wire logic [20:0] subAddr,
	input wire logic [2:0] subEn,
	input wire logic [7:0] rdData,
	output logic sdaOe,
	output logic wrEn,
	output logic [7:0] wrAddr,
	output logic [7:0] wrData,
	output logic [7:0] rdAddr,
	output logic ackPulse,
	output logic stopPulse,
	output logic softReset
);
	pwm_led_pkg::slave_state_type stateQ, stateD;
	logic [3:0] bitQ, bitD;
	logic [7:0] shiftQ, shiftD, txQ, txD, ptrQ, ptrD, wrAddrQ, wrAddrD, wrDataQ, wrDataD;
	logic firstQ, firstD, gcQ, gcD, mAckQ, mAckD, sdaOeQ, sdaOeD;
	logic wrEnQ, wrEnD, ackQ, ackD, stopQ, stopD, softQ, softD;
	logic sclPrevQ, sdaPrevQ;
	logic sclRise, sclFall, startSeen, stopSeen, match;
	logic [6:0] addr7;

	assign sclRise = scl & ~sclPrevQ;
	assign sclFall = ~scl & sclPrevQ;
	assign startSeen = scl & sclPrevQ & sdaPrevQ & ~sda;
	assign stopSeen = scl & sclPrevQ & ~sdaPrevQ & sda;
	assign addr7 = shiftQ[7:1];

	always_comb begin
		match = (addr7 == ownAddr) || (allEn && addr7 == allAddr);
		for (int k = 0; k < 3; k++) begin
			if (subEn[k] && addr7 == subAddr[7*k +: 7]) begin
				match = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		stateD = stateQ;
		bitD = bitQ;
		shiftD = shiftQ;
		txD = txQ;
		ptrD = ptrQ;
		wrAddrD = wrAddrQ;
		wrDataD = wrDataQ;
		firstD = firstQ;
		gcD = gcQ;
		mAckD = mAckQ;
		sdaOeD = sdaOeQ;
		wrEnD = 1'b0;
		ackD = 1'b0;
		stopD = 1'b0;
		softD = 1'b0;
		if (stopSeen) begin
			stopD = (stateQ != pwm_led_pkg::S_IDLE);
			stateD = pwm_led_pkg::S_IDLE;
			sdaOeD = 1'b0;
		end else if (startSeen) begin
			stateD = pwm_led_pkg::S_ADDR;
			bitD = 4'h0;
			sdaOeD = 1'b0;
		end else begin
			case (stateQ)
				pwm_led_pkg::S_ADDR, pwm_led_pkg::S_WRITE: begin
					if (sclRise) begin
						shiftD = {shiftQ[6:0], sda};
						bitD = bitQ + 4'h1;
					end else if (sclFall && bitQ == 4'h8) begin
						if (stateQ == pwm_led_pkg::S_ADDR) begin
							gcD = (addr7 == pwm_led_pkg::GENERAL_CALL) && !shiftQ[0];
							firstD = 1'b1;
							if (match || gcD) begin
								sdaOeD = 1'b1;
								stateD = pwm_led_pkg::S_ACK_ADDR;
							end else begin
								stateD = pwm_led_pkg::S_IDLE;
							end
						end else begin
							sdaOeD = 1'b1;
							stateD = pwm_led_pkg::S_ACK_WR;
							if (gcQ) begin
								softD = (shiftQ == pwm_led_pkg::SOFT_RESET_BYTE);
							end else if (firstQ) begin
								ptrD = shiftQ;
								firstD = 1'b0;
							end else begin
								wrEnD = 1'b1;
								ackD = 1'b1;
								wrAddrD = ptrQ;
								wrDataD = shiftQ;
								ptrD = ptrQ + 8'h01;
							end
						end
					end
				end
				pwm_led_pkg::S_ACK_ADDR: begin
					if (sclFall) begin
						bitD = 4'h0;
						if (shiftQ[0] && !gcQ) begin
							stateD = pwm_led_pkg::S_READ;
							txD = rdData;
							sdaOeD = ~rdData[7];
						end else begin
							stateD = pwm_led_pkg::S_WRITE;
							sdaOeD = 1'b0;
						end
					end
				end
				pwm_led_pkg::S_ACK_WR: begin
					if (sclFall) begin
						stateD = pwm_led_pkg::S_WRITE;
						bitD = 4'h0;
						sdaOeD = 1'b0;
					end
				end
				pwm_led_pkg::S_READ: begin
					if (sclRise) begin
						bitD = bitQ + 4'h1;
					end else if (sclFall) begin
						if (bitQ == 4'h8) begin
							sdaOeD = 1'b0;
							stateD = pwm_led_pkg::S_ACK_RD;
							ptrD = ptrQ + 8'h01;
						end else begin
							sdaOeD = ~txQ[6];
							txD = {txQ[6:0], 1'b0};
						end
					end
				end
				pwm_led_pkg::S_ACK_RD: begin
					if (sclRise) begin
						mAckD = ~sda;
					end else if (sclFall) begin
						bitD = 4'h0;
						if (mAckQ) begin
							stateD = pwm_led_pkg::S_READ;
							txD = rdData;
							sdaOeD = ~rdData[7];
						end else begin
							stateD = pwm_led_pkg::S_IDLE;
						end
					end
				end
				default: begin
					stateD = pwm_led_pkg::S_IDLE;
					sdaOeD = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stateQ <= pwm_led_pkg::S_IDLE;
			bitQ <= 4'h0;
			shiftQ <= 8'h00;
			txQ <= 8'h00;
			ptrQ <= 8'h00;
			wrAddrQ <= 8'h00;
			wrDataQ <= 8'h00;
			firstQ <= 1'b0;
			gcQ <= 1'b0;
			mAckQ <= 1'b0;
			sdaOeQ <= 1'b0;
			wrEnQ <= 1'b0;
			ackQ <= 1'b0;
			stopQ <= 1'b0;
			softQ <= 1'b0;
			sclPrevQ <= 1'b1;
			sdaPrevQ <= 1'b1;
		end else begin
			stateQ <= stateD;
			bitQ <= bitD;
			shiftQ <= shiftD;
			txQ <= txD;
			ptrQ <= ptrD;
			wrAddrQ <= wrAddrD;
			wrDataQ <= wrDataD;
			firstQ <= firstD;
			gcQ <= gcD;
			mAckQ <= mAckD;
			sdaOeQ <= sdaOeD;
			wrEnQ <= wrEnD;
			ackQ <= ackD;
			stopQ <= stopD;
			softQ <= softD;
			sclPrevQ <= scl;
			sdaPrevQ <= sda;
		end
	end

	assign sdaOe = sdaOeQ;
	assign wrEn = wrEnQ;
	assign wrAddr = wrAddrQ;
	assign wrData = wrDataQ;
	assign rdAddr = ptrQ;
	assign ackPulse = ackQ;
	assign stopPulse = stopQ;
	assign softReset = softQ;

endmodule // serial_slave

// [rtl/sixteen_channel_pwm_led_controller.sv]
`timescale 1ns/1ps
module sixteen_channel_pwm_led_controller (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic scl,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOutEn,
	input wire logic [5:0] addrPins,
	input wire logic extClk,
	input wire logic outEnable_n,
	output logic [15:0] channelOut,
	output logic [15:0] channelOutEn
);
	////////////////////////////////////////////////////////////////////////
	// reset release and pin synchronisers
	logic [1:0] rstPipeQ;
	logic rst_n;
	logic [9:0] pinsAQ, pinsBQ;
	logic sclS, sdaS, extS, oeS;
	logic [5:0] addrS;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rstPipeQ <= 2'b00;
		end else begin
			rstPipeQ <= {rstPipeQ[0], 1'b1};
		end
	end
	assign rst_n = rstPipeQ[1];

	// 50 clocks per bus bit at the top bus rate leaves margin for the sync delay
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pinsAQ <= 10'h378;
			pinsBQ <= 10'h378;
		end else begin
			pinsAQ <= {scl, sdaIn, extClk, outEnable_n, addrPins};
			pinsBQ <= pinsAQ;
		end
	end
	assign sclS = pinsBQ[9];
	assign sdaS = pinsBQ[8];
	assign extS = pinsBQ[7];
	assign oeS = pinsBQ[6];
	assign addrS = pinsBQ[5:0];

	////////////////////////////////////////////////////////////////////////
	// serial slave
	logic wrEn, ackPulse, stopPulse, softReset;
	logic [7:0] wrAddr, wrData, rdAddr, rdData;
	logic [7:0] mode1Q, mode1D, mode2Q, mode2D, allAddrQ, allAddrD, prescaleQ, prescaleD;
	logic [7:0] subQ [3];
	logic [7:0] subD [3];
	logic [7:0] ledRegQ [pwm_led_pkg::CHAN_BYTES];
	logic [7:0] ledRegD [pwm_led_pkg::CHAN_BYTES];
	logic [7:0] actRegQ [pwm_led_pkg::CHAN_BYTES];
	logic [7:0] actRegD [pwm_led_pkg::CHAN_BYTES];

	serial_slave slave (
		.clock(clock),
		.rst_n(rst_n),
		.scl(sclS),
		.sda(sdaS),
		.ownAddr({pwm_led_pkg::OWN_ADDR_TOP, addrS}),
		.allAddr(allAddrQ[7:1]),
		.allEn(mode1Q[pwm_led_pkg::MODE1_ALL_EN]),
		.subAddr({subQ[2][7:1], subQ[1][7:1], subQ[0][7:1]}),
		.subEn(mode1Q[pwm_led_pkg::MODE1_SUB_EN_LO +: 3]),
		.rdData(rdData),
		.sdaOe(sdaOutEn),
		.wrEn(wrEn),
		.wrAddr(wrAddr),
		.wrData(wrData),
		.rdAddr(rdAddr),
		.ackPulse(ackPulse),
		.stopPulse(stopPulse),
		.softReset(softReset)
	);
	// open-drain bus pin: only ever pulls low
	assign sdaOut = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// register file
	function automatic logic [7:0] chanReset(input int idx);
		return (idx % 4 == 3) ? pwm_led_pkg::CHAN_OFF_H_RESET : pwm_led_pkg::CHAN_BYTE_RESET;
	endfunction

	function automatic logic inChanRange(input logic [7:0] a);
		return (a >= pwm_led_pkg::REG_CHAN_BASE) && (a <= pwm_led_pkg::REG_CHAN_LAST);
	endfunction

	always_comb begin
		logic [7:0] idx;
		logic apply;
		idx = wrAddr - pwm_led_pkg::REG_CHAN_BASE;
		apply = mode2Q[pwm_led_pkg::MODE2_ON_ACK] ? ackPulse : stopPulse;
		mode1D = mode1Q;
		mode2D = mode2Q;
		allAddrD = allAddrQ;
		prescaleD = prescaleQ;
		subD = subQ;
		ledRegD = ledRegQ;
		actRegD = actRegQ;
		if (softReset) begin
			mode1D = pwm_led_pkg::MODE1_RESET;
			mode2D = pwm_led_pkg::MODE2_RESET;
			allAddrD = pwm_led_pkg::ALL_ADDR_RESET;
			prescaleD = pwm_led_pkg::PRESCALE_RESET;
			for (int k = 0; k < 3; k++) begin
				subD[k] = pwm_led_pkg::SUB_RESET;
			end
			for (int i = 0; i < pwm_led_pkg::CHAN_BYTES; i++) begin
				ledRegD[i] = chanReset(i);
				actRegD[i] = chanReset(i);
			end
		end else begin
			if (wrEn) begin
				case (wrAddr)
					pwm_led_pkg::REG_MODE1: mode1D = wrData;
					pwm_led_pkg::REG_MODE2: mode2D = wrData;
					pwm_led_pkg::REG_SUB1: subD[0] = wrData;
					pwm_led_pkg::REG_SUB2: subD[1] = wrData;
					pwm_led_pkg::REG_SUB3: subD[2] = wrData;
					pwm_led_pkg::REG_ALL_ADDR: allAddrD = wrData;
					pwm_led_pkg::REG_PRESCALE: prescaleD = wrData;
					default: begin
						if (inChanRange(wrAddr)) begin
							ledRegD[idx[5:0]] = wrData;
						end
					end
				endcase
			end
			// with MODE2_ON_ACK clear, whole-array take-over at stop keeps an on/off pair from mixing old and new halves
			if (apply) begin
				actRegD = ledRegD;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode1Q <= pwm_led_pkg::MODE1_RESET;
			mode2Q <= pwm_led_pkg::MODE2_RESET;
			allAddrQ <= pwm_led_pkg::ALL_ADDR_RESET;
			prescaleQ <= pwm_led_pkg::PRESCALE_RESET;
			for (int k = 0; k < 3; k++) begin
				subQ[k] <= pwm_led_pkg::SUB_RESET;
			end
			for (int i = 0; i < pwm_led_pkg::CHAN_BYTES; i++) begin
				ledRegQ[i] <= chanReset(i);
				actRegQ[i] <= chanReset(i);
			end
		end else begin
			mode1Q <= mode1D;
			mode2Q <= mode2D;
			allAddrQ <= allAddrD;
			prescaleQ <= prescaleD;
			subQ <= subD;
			ledRegQ <= ledRegD;
			actRegQ <= actRegD;
		end
	end

	// readback shows the programmed values, not the ones in effect
	always_comb begin
		logic [7:0] ridx;
		ridx = rdAddr - pwm_led_pkg::REG_CHAN_BASE;
		case (rdAddr)
			pwm_led_pkg::REG_MODE1: rdData = mode1Q;
			pwm_led_pkg::REG_MODE2: rdData = mode2Q;
			pwm_led_pkg::REG_SUB1: rdData = subQ[0];
			pwm_led_pkg::REG_SUB2: rdData = subQ[1];
			pwm_led_pkg::REG_SUB3: rdData = subQ[2];
			pwm_led_pkg::REG_ALL_ADDR: rdData = allAddrQ;
			pwm_led_pkg::REG_PRESCALE: rdData = prescaleQ;
			default: rdData = inChanRange(rdAddr) ? ledRegQ[ridx[5:0]] : 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// timebase, prescaler and shared counter
	logic [1:0] oscCntQ, oscCntD;
	logic extPrevQ;
	logic [7:0] presCntQ, presCntD;
	logic [11:0] pwmCntQ, pwmCntD;
	logic tick, step;

	always_comb begin
		oscCntD = (oscCntQ == pwm_led_pkg::OSC_DIV_LAST) ? 2'h0 : oscCntQ + 2'h1;
		// an external clock near the system rate aliases: the sampler sees at most half of it
		tick = mode1Q[pwm_led_pkg::MODE1_EXT_CLK] ? (extS & ~extPrevQ) : (oscCntQ == pwm_led_pkg::OSC_DIV_LAST);
		step = tick && (presCntQ >= prescaleQ);
		presCntD = presCntQ;
		if (tick) begin
			presCntD = step ? 8'h00 : presCntQ + 8'h01;
		end
		pwmCntD = step ? pwmCntQ + 12'h001 : pwmCntQ;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			oscCntQ <= 2'h0;
			extPrevQ <= 1'b0;
			presCntQ <= 8'h00;
			pwmCntQ <= 12'h000;
		end else begin
			oscCntQ <= oscCntD;
			extPrevQ <= extS;
			presCntQ <= presCntD;
			pwmCntQ <= pwmCntD;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// channel levels and pin drive
	logic [15:0] levelQ, levelD, outQ, outD, outEnQ, outEnD;

	function automatic logic chanLevel(input logic prev, input logic stepNow, input logic [11:0] cnt,
		input logic [7:0] onL, input logic [7:0] onH, input logic [7:0] offL, input logic [7:0] offH);
		logic lvl;
		lvl = prev;
		if (stepNow && cnt == {onH[3:0], onL}) begin
			lvl = 1'b1;
		end
		if (stepNow && cnt == {offH[3:0], offL}) begin
			lvl = 1'b0;
		end
		if (onH[pwm_led_pkg::CHAN_FULL_BIT]) begin
			lvl = 1'b1;
		end
		// full off outranks full on
		if (offH[pwm_led_pkg::CHAN_FULL_BIT]) begin
			lvl = 1'b0;
		end
		return lvl;
	endfunction

	always_comb begin
		logic lvl;
		logic hiz;
		lvl = 1'b0;
		hiz = 1'b0;
		for (int i = 0; i < pwm_led_pkg::CHANNELS; i++) begin
			levelD[i] = chanLevel(levelQ[i], step, pwmCntD, actRegQ[4*i], actRegQ[4*i+1],
				actRegQ[4*i+2], actRegQ[4*i+3]);
			lvl = levelQ[i];
			hiz = 1'b0;
			if (oeS) begin
				hiz = mode2Q[pwm_led_pkg::MODE2_FORCE_HIZ];
				lvl = mode2Q[pwm_led_pkg::MODE2_FORCE_LVL];
			end
			if (hiz) begin
				outD[i] = 1'b0;
				outEnD[i] = 1'b0;
			end else if (mode2Q[pwm_led_pkg::MODE2_TOTEM]) begin
				outD[i] = lvl;
				outEnD[i] = 1'b1;
			end else begin
				outD[i] = 1'b0;
				outEnD[i] = ~lvl;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			levelQ <= 16'h0000;
			outQ <= 16'h0000;
			outEnQ <= pwm_led_pkg::OUT_EN_RESET;
		end else begin
			levelQ <= levelD;
			outQ <= outD;
			outEnQ <= outEnD;
		end
	end

	assign channelOut = outQ;
	assign channelOutEn = outEnQ;

endmodule // sixteen_channel_pwm_led_controller

// [tb/pwm_led_sva.sv]
`timescale 1ns/1ps
module pwm_led_sva (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic scl,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOutEn,
	input wire logic outEnable_n,
	input wire logic [15:0] channelOut,
	input wire logic [15:0] channelOutEn
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////////////
	sequence startSeen;
		scl && $fell(sdaIn);
	endsequence
	sequence ackHeld;
		sdaOutEn [*8];
	endsequence
	function automatic logic uniform(input logic [15:0] v);
		return v == 16'h0000 || v == 16'hffff;
	endfunction
	////////////////////////////////////////////////////////////////////////
	reset_vals_a: assert property ($rose(reset_n) |-> channelOut == 16'h0000 && channelOutEn == 16'hffff)
		else $error("outputs not driven low after reset");
	sda_const_a: assert property (sdaOut == 1'b0)
		else $error("data pin value not held low");
	// a change while the bus clock is high would look like a start or stop
	sda_steady_a: assert property (scl && $past(scl) |-> $stable(sdaOutEn))
		else $error("data pin pull changed while bus clock high");
	start_quiet_a: assert property (startSeen |-> !sdaOutEn [*8])
		else $error("data pin pulled during address phase");
	ack_rise_a: assert property ($rose(sdaOutEn) |-> !scl)
		else $error("data pin pulled while bus clock high");
	ack_fall_a: assert property ($fell(sdaOutEn) |-> !scl)
		else $error("data pin released while bus clock high");
	ack_hold_a: assert property ($rose(sdaOutEn) |-> ackHeld)
		else $error("data pin pull too short");
	// forced state may differ in mode, but never per channel
	oe_force_a: assert property (outEnable_n [*5] |-> uniform(channelOut) && uniform(channelOutEn))
		else $error("forced outputs not uniform");
	drive_form_a: assert property (!outEnable_n [*5] |-> channelOutEn == 16'hffff || channelOut == 16'h0000)
		else $error("outputs neither totem nor open drain");
endmodule // pwm_led_sva

bind sixteen_channel_pwm_led_controller pwm_led_sva chk (
	.clock(clock),
	.reset_n(reset_n),
	.scl(scl),
	.sdaIn(sdaIn),
	.sdaOut(sdaOut),
	.sdaOutEn(sdaOutEn),
	.outEnable_n(outEnable_n),
	.channelOut(channelOut),
	.channelOutEn(channelOutEn)
);

// [tb/bus_master_model.sv]
`timescale 1ns/1ps
module bus_master_model (
	input wire logic clock,
	input wire logic sdaLine,
	output logic scl,
	output logic sdaLow
);
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic waitClk(input int n);
		repeat (n) @(posedge clock);
	endtask
	////////////////////////////////////////////////////////////////////////
	// 50 clocks a bit gives 1 MHz, the fastest allowed
	task automatic bitCycle(input logic val, output logic seen);
		waitClk(12);
		sdaLow <= !val;
		waitClk(13);
		scl <= 1'b1;
		waitClk(25);
		seen = sdaLine;
		scl <= 1'b0;
	endtask
	task automatic start();
		sdaLow <= 1'b1;
		waitClk(25);
		scl <= 1'b0;
	endtask
	task automatic stop();
		waitClk(12);
		sdaLow <= 1'b1;
		waitClk(13);
		scl <= 1'b1;
		waitClk(12);
		sdaLow <= 1'b0;
		waitClk(25);
	endtask
	task automatic sendByte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitCycle(b[i], s);
		end
		bitCycle(1'b1, s);
		ack = !s;
	endtask
	task automatic getByte(output logic [7:0] b, input logic nack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitCycle(1'b1, b[i]);
		end
		bitCycle(nack, s);
	endtask
endmodule // bus_master_model

// [tb/tb_sixteen_channel_pwm_led_controller.sv]
`timescale 1ns/1ps
module tb_sixteen_channel_pwm_led_controller;
	localparam logic [7:0] DEV = 8'haa;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic outEnable_n = 1'b0;
	logic [5:0] addrPins = 6'h15;
	logic scl, sdaLow, sdaOut, sdaOutEn, sdaLine;
	logic [15:0] channelOut, channelOutEn;
	int err_count = 0;
	int check_count = 0;
	logic [1:0] extDiv = 2'h0;
	always #10 clock = ~clock;
	// external timebase at a quarter of the system clock, well inside what the sampler follows
	always @(posedge clock) extDiv <= extDiv + 2'h1;
	// pulled-up line: low when either side pulls
	assign sdaLine = !(sdaLow || (sdaOutEn && !sdaOut));
	bus_master_model master (.clock(clock), .sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow));
	sixteen_channel_pwm_led_controller DUT (.clock(clock), .reset_n(reset_n), .scl(scl), .sdaIn(sdaLine),
		.sdaOut(sdaOut), .sdaOutEn(sdaOutEn), .addrPins(addrPins), .extClk(extDiv[1]), .outEnable_n(outEnable_n),
		.channelOut(channelOut), .channelOutEn(channelOutEn));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (err_count == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic xfer(input logic [7:0] dev, input logic [7:0] ptr, input logic [31:0] dat, input int n,
		output logic ok);
		logic a;
		master.start();
		master.sendByte(dev, ok);
		master.sendByte(ptr, a);
		ok = ok && a;
		for (int k = 0; k < n; k++) begin
			master.sendByte(dat[8*k +: 8], a);
			ok = ok && a;
		end
		master.stop();
	endtask
	task automatic rd(input logic [7:0] dev, input logic [7:0] ptr, output logic [7:0] v);
		logic a;
		xfer(dev, ptr, 32'h0, 0, a);
		master.start();
		master.sendByte(dev | 8'h01, a);
		master.getByte(v, 1'b1);
		master.stop();
	endtask
	task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
		logic a;
		xfer(DEV, ptr, {24'h0, d}, 1, a);
		check({15'h0, a}, 16'h0001);
	endtask
	task automatic waitCh0(input logic b);
		for (int i = 0; i < 17000 && channelOut[0] !== b; i++) @(posedge clock);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [7:0] v;
		check(channelOut, 16'h0000);
		check(channelOutEn, 16'hffff);
		rd(DEV, pwm_led_pkg::REG_PRESCALE, v);
		check({8'h00, v}, 16'h001e);
		rd(DEV, pwm_led_pkg::REG_MODE2, v);
		check({8'h00, v}, 16'h0004);
		rd(DEV, pwm_led_pkg::REG_MODE1, v);
		check({8'h00, v}, 16'h0001);
	endtask
	task automatic t_addr();
		logic ok;
		logic [7:0] v;
		xfer(8'h20, pwm_led_pkg::REG_SUB1, 32'h0000008a, 1, ok);
		check({15'h0, ok}, 16'h0000);
		xfer(8'he0, pwm_led_pkg::REG_SUB1, 32'h0000008a, 1, ok);
		check({15'h0, ok}, 16'h0001);
		rd(8'he0, pwm_led_pkg::REG_SUB1, v);
		check({8'h00, v}, 16'h008a);
		wr(pwm_led_pkg::REG_MODE1, 8'h02);
		xfer(8'h8a, pwm_led_pkg::REG_SUB2, 32'h0, 0, ok);
		check({15'h0, ok}, 16'h0001);
		xfer(8'he0, pwm_led_pkg::REG_SUB2, 32'h0, 0, ok);
		check({15'h0, ok}, 16'h0000);
	endtask
	task automatic t_pwm();
		logic ok;
		logic prev;
		int hi;
		int len;
		// smallest prescale keeps a period at 8192 clocks
		wr(pwm_led_pkg::REG_PRESCALE, 8'h00);
		xfer(DEV, pwm_led_pkg::REG_CHAN_BASE, 32'h03000100, 4, ok);
		check({15'h0, ok}, 16'h0001);
		xfer(DEV, pwm_led_pkg::REG_CHAN_BASE + 8'h04, 32'h00001000, 4, ok);
		check({15'h0, ok}, 16'h0001);
		waitCh0(1'b0);
		waitCh0(1'b1);
		hi = 1;
		prev = 1'b1;
		for (len = 0; len < 9000; len++) begin
			@(posedge clock);
			if (channelOut[0] === 1'b1 && prev === 1'b0) break;
			if (channelOut[0] === 1'b1) hi++;
			prev = channelOut[0];
		end
		check(16'(len + 1), 16'h2000);
		check(16'(hi), 16'h0400);
		check({15'h0, channelOut[1]}, 16'h0001);
		check({channelOut[15:2], 2'b00}, 16'h0000);
	endtask
	task automatic t_ext();
		int hi;
		// four clocks per external tick stretches the 512-count pulse to 2048 clocks
		wr(pwm_led_pkg::REG_MODE1, 8'h42);
		waitCh0(1'b0);
		waitCh0(1'b1);
		for (hi = 0; hi < 3000 && channelOut[0] === 1'b1; hi++) @(posedge clock);
		check(16'(hi), 16'h0800);
	endtask
	task automatic t_ack();
		logic a;
		wr(pwm_led_pkg::REG_MODE2, 8'h0c);
		master.start();
		master.sendByte(DEV, a);
		master.sendByte(pwm_led_pkg::REG_CHAN_BASE + 8'h09, a);
		master.sendByte(8'h10, a);
		master.sendByte(8'h00, a);
		master.sendByte(8'h00, a);
		check({15'h0, channelOut[2]}, 16'h0001);
		master.stop();
		wr(pwm_led_pkg::REG_MODE2, 8'h04);
		master.start();
		master.sendByte(DEV, a);
		master.sendByte(pwm_led_pkg::REG_CHAN_BASE + 8'h0b, a);
		master.sendByte(8'h10, a);
		check({15'h0, channelOut[2]}, 16'h0001);
		master.stop();
		check({15'h0, channelOut[2]}, 16'h0000);
	endtask
	task automatic t_oe();
		outEnable_n <= 1'b1;
		repeat (6) @(posedge clock);
		check(channelOut, 16'h0000);
		check(channelOutEn, 16'hffff);
		wr(pwm_led_pkg::REG_MODE2, 8'h05);
		check(channelOut, 16'hffff);
		wr(pwm_led_pkg::REG_MODE2, 8'h06);
		check(channelOutEn, 16'h0000);
		wr(pwm_led_pkg::REG_MODE2, 8'h00);
		outEnable_n <= 1'b0;
		repeat (8) @(posedge clock);
		check(channelOut, 16'h0000);
		check({14'h0, channelOutEn[2:1]}, 16'h0002);
	endtask
	task automatic t_soft();
		logic ok;
		logic [7:0] v;
		xfer(8'h00, pwm_led_pkg::SOFT_RESET_BYTE, 32'h0, 0, ok);
		check({15'h0, ok}, 16'h0001);
		check(channelOut, 16'h0000);
		check(channelOutEn, 16'hffff);
		rd(DEV, pwm_led_pkg::REG_MODE2, v);
		check({8'h00, v}, 16'h0004);
		rd(DEV, pwm_led_pkg::REG_PRESCALE, v);
		check({8'h00, v}, 16'h001e);
		rd(8'he0, pwm_led_pkg::REG_MODE1, v);
		check({8'h00, v}, 16'h0001);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		// tests need about 80k cycles at worst
		repeat (90000) @(posedge clock);
		err_count++;
		tally_and_finish();
	end
	initial begin
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		repeat (5) @(posedge clock);
		t_reset();
		t_addr();
		t_pwm();
		t_ext();
		t_oe();
		t_ack();
		t_soft();
		tally_and_finish();
	end
endmodule // tb_sixteen_channel_pwm_led_controller
